// ==== hdl/smc_pkg.sv ====
package smc_pkg;

    // register indices, which are also the frame's 7-bit address codes
    localparam logic [6:0] ADDR_MODE_SUPPLY = 7'h01;
    localparam logic [6:0] ADDR_HW_CONFIG   = 7'h02;

    localparam int FRAME_BITS = 16;
    localparam int ADDR_BITS  = 7;

    // mode_and_supply_control field positions
    localparam int MS_MODE_LSB = 6;
    localparam int MS_V3_BIT   = 5;
    localparam int MS_V2_LSB   = 3;
    localparam int MS_OVR_BIT  = 2;
    localparam int MS_RT_LSB   = 0;

    // hardware_config_control field positions
    localparam int HW_VSEL_BIT  = 7;
    localparam int HW_SRO_BIT   = 6;
    localparam int HW_FO_BIT    = 5;
    localparam int HW_UVK_BIT   = 4;
    localparam int HW_LS_BIT    = 3;
    localparam int HW_RSV_BIT   = 2;
    localparam int HW_LSSTP_BIT = 1;
    localparam int HW_CFG_BIT   = 0;

    // reset values and masks; a set bit in a keep mask keeps the previous content
    localparam logic [7:0] MS_RST_VAL       = 8'h00;
    localparam logic [7:0] HW_RST_VAL       = 8'h00;
    localparam logic [7:0] MS_RESTART_KEEP  = 8'h23;
    localparam logic [7:0] HW_RESTART_KEEP  = 8'hD9;
    localparam logic [7:0] HW_SOFT_KEEP     = 8'h88;
    localparam logic [7:0] HW_WRITE_MASK    = 8'hFB;

    localparam logic [1:0] SECOND_REG_OFF   = 2'h0;
    localparam logic [1:0] WD_LIMIT_DEFAULT = 2'h2;
    localparam logic [1:0] WD_LIMIT_FAST    = 2'h1;

    // reset output low time after a soft reset, in clk_sys cycles
    localparam int SOFT_RST_LOW_CYCLES = 16;

    typedef enum logic [1:0] {
        SMC_MODE_NORMAL = 2'h0,
        SMC_MODE_SLEEP  = 2'h1,
        SMC_MODE_STOP   = 2'h2,
        SMC_MODE_SOFTRST = 2'h3
    } smc_mode_t;

    // frame bit 15 down to bit 0
    typedef struct packed {
        logic [7:0] data;
        logic       wr;
        logic [6:0] addr;
    } smc_frame_t;

    typedef struct packed {
        smc_mode_t  mode;
        logic [1:0] second_regulator_enable;
        logic [1:0] main_reset_threshold;
        logic       third_regulator_voltage_sel;
        logic       load_sharing_select;
        logic       load_sharing_in_stop;
        logic       third_regulator_uv_keep;
        logic [1:0] wd_fail_limit;
    } smc_ctrl_t;

endpackage

// ==== hdl/smc_sync.sv ====
`timescale 1ns/1ps
module smc_sync #(
    parameter int         W       = 1,
    parameter logic [0:0] RST_VAL = 1'h0
) (
    input  wire logic         clk_sys, // system clock
    input  wire logic         resetn,  // async reset, active low
    input  wire logic [W-1:0] din,     // asynchronous inputs
    output logic      [W-1:0] dout     // filtered levels
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] dout_nxt;

    // a bit changes only once the second and third stages agree
    always_comb
    begin
        dout_nxt = (~(s2_r ^ s3_r) & s2_r) | ((s2_r ^ s3_r) & dout);
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            s1_r <= {W{RST_VAL}};
            s2_r <= {W{RST_VAL}};
            s3_r <= {W{RST_VAL}};
            dout <= {W{RST_VAL}};
        end
        else
        begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            dout <= dout_nxt;
        end
    end
endmodule

// ==== hdl/smc_spi_shift.sv ====
`timescale 1ns/1ps
module smc_spi_shift (
    input  wire logic              clk_sys,     // system clock
    input  wire logic              resetn,      // async reset, active low
    input  wire logic              sck,         // synchronised serial clock
    input  wire logic              csn,         // synchronised chip select, low active
    input  wire logic              sdi,         // synchronised serial data in
    input  wire logic [7:0]        status_byte, // sent during the address byte
    input  wire logic [7:0]        rd_byte,     // content of the addressed register
    output logic      [7:0]        addr_byte,   // first byte once eight bits are in
    output smc_pkg::smc_frame_t    frame,       // last complete frame
    output logic                   frame_valid, // one-cycle pulse at chip select rise
    output logic                   sdo,         // serial data out
    output logic                   sdo_oe       // drive enable for sdo
);
    logic [15:0] rx_r;
    logic [15:0] rx_nxt;
    logic [4:0]  cnt_r;
    logic [4:0]  cnt_nxt;
    logic [7:0]  tx_r;
    logic [7:0]  tx_nxt;
    logic        sck_d_r;
    logic        csn_d_r;
    logic        sdo_nxt;
    logic        fv_nxt;
    smc_pkg::smc_frame_t frame_nxt;

    assign addr_byte = rx_r[15:8];

    // lsb of the frame goes first on the wire, in both directions
    always_comb
    begin
        rx_nxt    = rx_r;
        cnt_nxt   = cnt_r;
        tx_nxt    = tx_r;
        sdo_nxt   = sdo;
        fv_nxt    = 1'b0;
        frame_nxt = frame;
        if (csn_d_r && !csn)
        begin
            cnt_nxt = 5'h00;
            tx_nxt  = status_byte;
            sdo_nxt = status_byte[0];
        end
        else if (!csn && sck && !sck_d_r)
        begin
            rx_nxt = {sdi, rx_r[15:1]};
            if (cnt_r != 5'h1F)
                cnt_nxt = cnt_r + 5'h01;
        end
        else if (!csn && !sck && sck_d_r)
        begin
            if (cnt_r == 5'h08)
            begin
                tx_nxt  = rd_byte;
                sdo_nxt = rd_byte[0];
            end
            else
            begin
                tx_nxt  = {1'b0, tx_r[7:1]};
                sdo_nxt = tx_r[1];
            end
        end
        // only frames of exactly sixteen bits count
        if (!csn_d_r && csn && cnt_r == 5'(smc_pkg::FRAME_BITS))
        begin
            fv_nxt    = 1'b1;
            frame_nxt = smc_pkg::smc_frame_t'(rx_r);
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            rx_r        <= 16'h0000;
            cnt_r       <= 5'h00;
            tx_r        <= 8'h00;
            sck_d_r     <= 1'b0;
            csn_d_r     <= 1'b1;
            sdo         <= 1'b0;
            sdo_oe      <= 1'b0;
            frame_valid <= 1'b0;
            frame       <= '0;
        end
        else
        begin
            rx_r        <= rx_nxt;
            cnt_r       <= cnt_nxt;
            tx_r        <= tx_nxt;
            sck_d_r     <= sck;
            csn_d_r     <= csn;
            sdo         <= sdo_nxt;
            sdo_oe      <= !csn;
            frame_valid <= fv_nxt;
            frame       <= frame_nxt;
        end
    end
endmodule

// ==== hdl/smc_regs.sv ====
// What this block does
// - a frame is sixteen bits: address byte with access bit, then data byte
// - frame bit 7 clear reads the register, set writes the data byte
// - register bits D0 to D7 are frame bits 8 to 15
// - reserved bits always read zero; host writes zero there
// - control bits hold their value unless hardware-modifiable fields update them
// - power-on reset loads reset values; soft reset too but keeps hardware config bits 7 and 3; restart loads restart values
// - mode field bits 7:6: normal, sleep, stop; 11 executes soft reset
// - a write never moves the mode from stop directly to sleep
// - entering restart rewrites the mode field to normal
// - restart or overtemperature clears the second regulator field to off
// - bit 5 switches the third regulator off or on
// - bits 4:3 pick second regulator: off, normal, normal+stop, always
// - overvoltage always sets flag; restart request only when bit 2 set
// - bits 1:0 pick one of four main reset thresholds
// - during a write the output shows the previous register content
// - soft reset pulls reset output low unless the select bit 6 is set
// - software bit 5 forces failure outputs; else only failures drive them
// - clearing the software bit keeps failure-driven outputs; status clear releases
// - restart clears the software failure bit; the outputs are released unless the failure status is still set
// - bit 4 clear shuts third regulator at supply undervoltage; set keeps it
// - bit 7 picks third regulator voltage; bit 3 picks load sharing
// - bit 0 picks restart after second or first watchdog failure
`timescale 1ns/1ps
module smc_regs #(
    parameter int SOFT_RST_CYCLES = smc_pkg::SOFT_RST_LOW_CYCLES
) (
    input  wire logic         clk_sys,                   // system clock, 250 MHz
    input  wire logic         resetn,                    // power-on reset, async, low
    input  wire logic         spi_sck,                   // serial clock pin
    input  wire logic         spi_csn,                   // chip select pin, low active
    input  wire logic         spi_sdi,                   // serial data in pin
    output logic              spi_sdo_out,               // serial data out value
    output logic              spi_sdo_oe,                // serial data out drive enable
    input  wire logic [7:0]   status_byte,               // shifted out with the address
    input  wire logic         restart_enter,             // pulse: restart mode entered
    input  wire logic         overtemp_event,            // pulse: overtemperature
    input  wire logic         overvoltage_event,         // pulse: main overvoltage
    input  wire logic         supply_undervoltage,       // level: supply undervoltage
    input  wire logic         failure_status,            // level: failure status bit set
    output smc_pkg::smc_ctrl_t ctrl,                     // decoded control fields
    output logic              third_regulator_enable,    // third regulator on
    output logic              main_overvoltage_flag_set, // pulse: set overvoltage flag
    output logic              ov_reaction_req,           // pulse: restart/fail-safe request
    output logic              soft_reset_req,            // pulse: soft reset executed
    output logic              reset_output_n,            // reset output, low active
    output logic              failure_outputs            // failure outputs active
);
    typedef enum logic [1:0] {
        ST_RUN  = 2'b01,
        ST_SRST = 2'b10
    } smc_st_t;

    localparam logic [7:0] SRST_LOAD = 8'(SOFT_RST_CYCLES - 1);

    logic [2:0]          pins_s;
    logic [7:0]          addr_byte;
    logic [7:0]          rd_byte;
    smc_pkg::smc_frame_t frame;
    logic                frame_valid;
    logic                sdo_i;
    logic                sdo_oe_i;

    logic [7:0]          ms_r;
    logic [7:0]          ms_nxt;
    logic [7:0]          hw_r;
    logic [7:0]          hw_nxt;
    logic                soft_w;
    logic                ms_wr;
    logic                hw_wr;
    smc_pkg::smc_mode_t  wmode;

    smc_st_t             st_r;
    smc_st_t             st_nxt;
    logic [7:0]          scnt_r;
    logic [7:0]          scnt_nxt;

    smc_pkg::smc_ctrl_t  ctrl_nxt;
    logic                v3_nxt;
    logic                ovf_nxt;
    logic                ovr_nxt;
    logic                sreq_nxt;
    logic                ron_nxt;
    logic                fo_nxt;

    function automatic logic [7:0] reg_read(input logic [6:0] a,
                                            input logic [7:0] ms,
                                            input logic [7:0] hw);
        logic [7:0] v;
        v = 8'h00;
        if (a == smc_pkg::ADDR_MODE_SUPPLY)
            v = ms;
        else if (a == smc_pkg::ADDR_HW_CONFIG)
            v = hw & smc_pkg::HW_WRITE_MASK;
        return v;
    endfunction

    smc_sync #(
        .W       (3),
        .RST_VAL (1'h0)
    ) u_sync (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .din     ({~spi_csn, spi_sck, spi_sdi}),
        .dout    (pins_s)
    );

    // read data is the stored content, so a write shows the old value
    assign rd_byte = reg_read(addr_byte[6:0], ms_r, hw_r);

    smc_spi_shift u_shift (
        .clk_sys     (clk_sys),
        .resetn      (resetn),
        .sck         (pins_s[1]),
        .csn         (~pins_s[2]),
        .sdi         (pins_s[0]),
        .status_byte (status_byte),
        .rd_byte     (rd_byte),
        .addr_byte   (addr_byte),
        .frame       (frame),
        .frame_valid (frame_valid),
        .sdo         (sdo_i),
        .sdo_oe      (sdo_oe_i)
    );

    assign spi_sdo_out = sdo_i;
    assign spi_sdo_oe  = sdo_oe_i;

    // register file
    always_comb
    begin
        ms_nxt = ms_r;
        hw_nxt = hw_r;
        wmode  = smc_pkg::smc_mode_t'(frame.data[smc_pkg::MS_MODE_LSB +: 2]);
        ms_wr  = frame_valid && frame.wr && frame.addr == smc_pkg::ADDR_MODE_SUPPLY;
        hw_wr  = frame_valid && frame.wr && frame.addr == smc_pkg::ADDR_HW_CONFIG;
        soft_w = ms_wr && wmode == smc_pkg::SMC_MODE_SOFTRST;
        if (soft_w)
        begin
            ms_nxt = smc_pkg::MS_RST_VAL;
            hw_nxt = (hw_r & smc_pkg::HW_SOFT_KEEP)
                   | (smc_pkg::HW_RST_VAL & ~smc_pkg::HW_SOFT_KEEP);
        end
        else if (ms_wr)
        begin
            ms_nxt = frame.data;
            if (ms_r[smc_pkg::MS_MODE_LSB +: 2] == smc_pkg::SMC_MODE_STOP
                && wmode == smc_pkg::SMC_MODE_SLEEP)
                ms_nxt[smc_pkg::MS_MODE_LSB +: 2] = smc_pkg::SMC_MODE_STOP;
        end
        else if (hw_wr)
        begin
            hw_nxt = frame.data & smc_pkg::HW_WRITE_MASK;
        end
        if (overtemp_event)
            ms_nxt[smc_pkg::MS_V2_LSB +: 2] = smc_pkg::SECOND_REG_OFF;
        if (restart_enter)
        begin
            // mode to normal, second regulator off, software failure bit cleared
            ms_nxt = ms_nxt & smc_pkg::MS_RESTART_KEEP;
            hw_nxt = hw_nxt & smc_pkg::HW_RESTART_KEEP;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            ms_r <= smc_pkg::MS_RST_VAL;
            hw_r <= smc_pkg::HW_RST_VAL;
        end
        else
        begin
            ms_r <= ms_nxt;
            hw_r <= hw_nxt;
        end
    end

    // soft reset sequencer for the reset output
    always_comb
    begin
        st_nxt   = st_r;
        scnt_nxt = scnt_r;
        unique case (st_r)
            ST_RUN:
            begin
                if (soft_w && !hw_r[smc_pkg::HW_SRO_BIT])
                begin
                    st_nxt   = ST_SRST;
                    scnt_nxt = SRST_LOAD;
                end
            end
            ST_SRST:
            begin
                if (scnt_r == 8'h00)
                    st_nxt = ST_RUN;
                else
                    scnt_nxt = scnt_r - 8'h01;
            end
            default:
            begin
                st_nxt   = ST_RUN;
                scnt_nxt = 8'h00;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            st_r   <= ST_RUN;
            scnt_r <= 8'h00;
        end
        else
        begin
            st_r   <= st_nxt;
            scnt_r <= scnt_nxt;
        end
    end

    // registered outputs
    always_comb
    begin
        ctrl_nxt.mode                        = smc_pkg::smc_mode_t'(ms_r[smc_pkg::MS_MODE_LSB +: 2]);
        ctrl_nxt.second_regulator_enable     = ms_r[smc_pkg::MS_V2_LSB +: 2];
        ctrl_nxt.main_reset_threshold        = ms_r[smc_pkg::MS_RT_LSB +: 2];
        ctrl_nxt.third_regulator_voltage_sel = hw_r[smc_pkg::HW_VSEL_BIT];
        ctrl_nxt.load_sharing_select         = hw_r[smc_pkg::HW_LS_BIT];
        ctrl_nxt.load_sharing_in_stop        = hw_r[smc_pkg::HW_LSSTP_BIT];
        ctrl_nxt.third_regulator_uv_keep     = hw_r[smc_pkg::HW_UVK_BIT];
        ctrl_nxt.wd_fail_limit = hw_r[smc_pkg::HW_CFG_BIT] ? smc_pkg::WD_LIMIT_FAST
                                                            : smc_pkg::WD_LIMIT_DEFAULT;
        v3_nxt   = ms_r[smc_pkg::MS_V3_BIT]
                 && !(supply_undervoltage && !hw_r[smc_pkg::HW_UVK_BIT]);
        ovf_nxt  = overvoltage_event;
        ovr_nxt  = overvoltage_event && ms_r[smc_pkg::MS_OVR_BIT];
        sreq_nxt = soft_w;
        ron_nxt  = !(st_r == ST_SRST);
        fo_nxt   = hw_r[smc_pkg::HW_FO_BIT] || failure_status;
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl                      <= '0;
            third_regulator_enable    <= 1'b0;
            main_overvoltage_flag_set <= 1'b0;
            ov_reaction_req           <= 1'b0;
            soft_reset_req            <= 1'b0;
            reset_output_n            <= 1'b1;
            failure_outputs           <= 1'b0;
        end
        else
        begin
            ctrl                      <= ctrl_nxt;
            third_regulator_enable    <= v3_nxt;
            main_overvoltage_flag_set <= ovf_nxt;
            ov_reaction_req           <= ovr_nxt;
            soft_reset_req            <= sreq_nxt;
            reset_output_n            <= ron_nxt;
            failure_outputs           <= fo_nxt;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    sequence s_soft_pull;
        soft_w && !hw_r[smc_pkg::HW_SRO_BIT];
    endsequence

    sequence s_rst_low;
        ##2 !reset_output_n [*8];
    endsequence

    a_soft_rst_low: assert property (s_soft_pull |-> s_rst_low)
        else $error("reset output not held low after soft reset");
    a_soft_rst_quiet: assert property (soft_w && hw_r[smc_pkg::HW_SRO_BIT]
        |=> ##1 reset_output_n [*4])
        else $error("reset output pulled low although suppressed");
    a_stop_no_sleep: assert property (ms_wr && !restart_enter
        && wmode == smc_pkg::SMC_MODE_SLEEP
        && ms_r[7:6] == smc_pkg::SMC_MODE_STOP |=> ms_r[7:6] == smc_pkg::SMC_MODE_STOP)
        else $error("mode went from stop to sleep");
    a_restart_clear: assert property (restart_enter
        |=> ms_r[7:6] == smc_pkg::SMC_MODE_NORMAL
        && ms_r[smc_pkg::MS_V2_LSB +: 2] == smc_pkg::SECOND_REG_OFF
        && !hw_r[smc_pkg::HW_FO_BIT])
        else $error("restart did not clear mode, regulator or failure bit");
    a_overtemp_off: assert property (overtemp_event
        |=> ##1 ctrl.second_regulator_enable == smc_pkg::SECOND_REG_OFF)
        else $error("second regulator not switched off on overtemperature");
    a_ov_reaction: assert property (overvoltage_event |=> main_overvoltage_flag_set
        && ov_reaction_req == $past(ms_r[smc_pkg::MS_OVR_BIT]))
        else $error("overvoltage flag or reaction wrong");
    a_rsvd_zero: assert property (!hw_r[smc_pkg::HW_RSV_BIT])
        else $error("reserved bit set");
    a_fo_hold: assert property (failure_status |=> failure_outputs)
        else $error("failure outputs released while failure pending");
    a_uv_shut: assert property (supply_undervoltage && !hw_r[smc_pkg::HW_UVK_BIT]
        |=> !third_regulator_enable)
        else $error("third regulator kept on at undervoltage");
    a_wd_limit: assert property (hw_r[smc_pkg::HW_CFG_BIT]
        |=> ctrl.wd_fail_limit == smc_pkg::WD_LIMIT_FAST)
        else $error("watchdog failure limit not one");
endmodule

// ==== verification/smc_host.sv ====
`timescale 1ns/1ps
module smc_host (
    output logic     sck, // serial clock, idles low
    output logic     csn, // chip select, low active
    output logic     sdi, // serial data to the device
    input  wire logic sdo  // serial data from the device
);
    initial
    begin
        sck = 1'b0;
        csn = 1'b1;
        sdi = 1'b0;
    end

    // one whole frame, lsb first; sdo is taken late in the high phase
    task automatic xfer(input smc_pkg::smc_frame_t f, output logic [15:0] rx);
        logic [15:0] b;
        b = f;
        // step off the clock edge so pin changes never race the sampling flops
        #1;
        csn = 1'b0;
        for (int i = 0; i < 16; i++)
        begin
            sdi = b[i];
            #24 sck = 1'b1;
            #23 rx[i] = sdo;
            #1 sck = 1'b0;
        end
        #24 csn = 1'b1;
        // released data line must not look like the last bit
        sdi = ~b[15];
        #48;
    endtask
endmodule

// ==== verification/smc_regs_bench.sv ====
`timescale 1ns/1ps
module smc_regs_bench;
    localparam int SRC = 8;
    logic        clk_sys = 1'b0;
    logic        resetn = 1'b0;
    logic        sck, csn, sdi, sdo_out, sdo_oe, v3en, ovf, ovq, srq, rstout_n, fo;
    logic [7:0]  stat = 8'hA5;
    logic [2:0]  evt = 3'h0;
    logic        uv = 1'b0;
    logic        fst = 1'b0;
    logic [15:0] rx;
    int          num_errors = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    int          lowc = 0;
    int          sqc = 0;
    smc_pkg::smc_ctrl_t ctrl;
    wire         sdo = sdo_oe ? sdo_out : 1'bz;

    always #2 clk_sys = ~clk_sys;

    smc_host host (.sck(sck), .csn(csn), .sdi(sdi), .sdo(sdo));
    smc_regs #(.SOFT_RST_CYCLES(SRC)) dut (
        .clk_sys(clk_sys), .resetn(resetn), .spi_sck(sck), .spi_csn(csn), .spi_sdi(sdi),
        .spi_sdo_out(sdo_out), .spi_sdo_oe(sdo_oe), .status_byte(stat),
        .restart_enter(evt[0]), .overtemp_event(evt[1]), .overvoltage_event(evt[2]),
        .supply_undervoltage(uv), .failure_status(fst), .ctrl(ctrl),
        .third_regulator_enable(v3en), .main_overvoltage_flag_set(ovf),
        .ov_reaction_req(ovq), .soft_reset_req(srq), .reset_output_n(rstout_n),
        .failure_outputs(fo));

    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (rstout_n === 1'b0)
            lowc <= lowc + 1;
        if (srq === 1'b1)
            sqc <= sqc + 1;
        if (cyc == 20000)
        begin
            num_errors++;
            results();
        end
    end

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic [7:0] old);
        host.xfer({d, 1'b1, a}, rx);
        chk("old content", old, rx[15:8]);
    endtask

    // data byte of a read frame is all ones and must be ignored
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        host.xfer({8'hFF, 1'b0, a}, rx);
        chk("status", stat, rx[7:0]);
        chk("read", e, rx[15:8]);
    endtask

    task automatic pls(input logic [2:0] v);
        @(posedge clk_sys) evt <= v;
        @(posedge clk_sys) evt <= 3'h0;
        #1;
    endtask

    task automatic tick;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask

    task automatic tend(input string s);
        $display("test %s finished", s);
    endtask

    task automatic results;
        $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        repeat (12) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (10) @(posedge clk_sys);
        rd(7'h01, 8'h00);
        rd(7'h02, 8'h00);
        wr(7'h05, 8'h3C, 8'h00);
        rd(7'h05, 8'h00);
        chk("reset out", 8'h01, 8'(rstout_n));
        tend("reset");
        wr(7'h01, 8'hB7, 8'h00);
        rd(7'h01, 8'hB7);
        chk("mode", 8'h02, 8'(ctrl.mode));
        chk("second reg", 8'h02, 8'(ctrl.second_regulator_enable));
        chk("threshold", 8'h03, 8'(ctrl.main_reset_threshold));
        chk("third reg", 8'h01, 8'(v3en));
        wr(7'h01, 8'h74, 8'hB7);
        rd(7'h01, 8'hB4);
        wr(7'h01, 8'h34, 8'hB4);
        chk("mode", 8'h00, 8'(ctrl.mode));
        wr(7'h01, 8'h74, 8'h34);
        rd(7'h01, 8'h74);
        chk("mode", 8'h01, 8'(ctrl.mode));
        tend("mode");
        wr(7'h02, 8'hFB, 8'h00);
        rd(7'h02, 8'hFB);
        chk("voltage sel", 8'h01, 8'(ctrl.third_regulator_voltage_sel));
        chk("load share", 8'h01, 8'(ctrl.load_sharing_select));
        chk("wd limit", 8'h01, 8'(ctrl.wd_fail_limit));
        chk("ls in stop", 8'h01, 8'(ctrl.load_sharing_in_stop));
        chk("uv keep", 8'h01, 8'(ctrl.third_regulator_uv_keep));
        chk("fail out", 8'h01, 8'(fo));
        @(posedge clk_sys) uv <= 1'b1;
        tick;
        chk("third reg", 8'h01, 8'(v3en));
        wr(7'h02, 8'hCB, 8'hFB);
        chk("third reg", 8'h00, 8'(v3en));
        chk("fail out", 8'h00, 8'(fo));
        @(posedge clk_sys) uv <= 1'b0;
        @(posedge clk_sys) fst <= 1'b1;
        tick;
        chk("fail out", 8'h01, 8'(fo));
        wr(7'h02, 8'hEB, 8'hCB);
        wr(7'h02, 8'hCB, 8'hEB);
        chk("fail out", 8'h01, 8'(fo));
        @(posedge clk_sys) fst <= 1'b0;
        tick;
        chk("fail out", 8'h00, 8'(fo));
        tend("hardware");
        pls(3'h4);
        chk("ov flag", 8'h01, 8'(ovf));
        chk("ov req", 8'h01, 8'(ovq));
        wr(7'h01, 8'h70, 8'h74);
        pls(3'h4);
        chk("ov flag", 8'h01, 8'(ovf));
        chk("ov req", 8'h00, 8'(ovq));
        pls(3'h2);
        tick;
        rd(7'h01, 8'h60);
        wr(7'h01, 8'h7B, 8'h60);
        wr(7'h02, 8'hEB, 8'hCB);
        pls(3'h1);
        tick;
        rd(7'h01, 8'h23);
        rd(7'h02, 8'hC9);
        chk("fail out", 8'h00, 8'(fo));
        tend("events");
        lowc = 0;
        sqc = 0;
        wr(7'h01, 8'hC0, 8'h23);
        tick;
        chk("reset low", 8'h00, 8'(lowc));
        chk("soft pulse", 8'h01, 8'(sqc));
        rd(7'h01, 8'h00);
        rd(7'h02, 8'h88);
        chk("wd limit", 8'h02, 8'(ctrl.wd_fail_limit));
        wr(7'h01, 8'hC0, 8'h00);
        tick;
        tick;
        chk("reset low", 8'(SRC), 8'(lowc));
        chk("reset out", 8'h01, 8'(rstout_n));
        tend("soft reset");
        results();
    end
endmodule
